// ---- verilog/sacc_pkg.sv ----
// Shared constants and carrier types for the compare-code converter control block.
package sacc_pkg;
   localparam logic [7:0] PERIPH_ADDR_CODE  = 8'h02;
   localparam logic [7:0] REGFILE_ADDR_SEL  = 8'h21;
   localparam logic [3:0] BUF_HIGH_INDEX    = 4'he;
   localparam logic [3:0] BUF_LOW_INDEX     = 4'hf;
   localparam int         CODE_WIDTH        = 4;
   localparam int         SEL_WIDTH         = 3;
   localparam int         NUM_INPUTS        = 8;
   localparam int         RESULT_BIT_POS    = 0;
   localparam int         SEL_FIELD_LSB     = 1;
   localparam logic [3:0] HIGH_NIBBLE_READ  = 4'h0;
   localparam logic [3:0] CODE_RESET_VALUE  = 4'h0;
   localparam logic [2:0] SEL_RESET_VALUE   = 3'h0;
   localparam int         DOWN_PIN_FIRST    = 1;
   localparam int         DOWN_PIN_LAST     = 4;

   typedef struct packed {
      logic       put_stb;
      logic       get_stb;
      logic [7:0] periph_addr;
      logic [7:0] put_data;
   } sacc_periph_req_t;

   typedef struct packed {
      logic       peek_stb;
      logic       poke_stb;
      logic [7:0] rf_addr;
      logic [3:0] poke_data;
   } sacc_rf_req_t;

   typedef struct packed {
      logic [3:0] code;
      logic [2:0] sel;
      logic       result;
      logic [7:0] get_data;
      logic       get_valid;
      logic [3:0] peek_data;
      logic       peek_valid;
      logic [7:0] pin_mask;
   } sacc_state_t;
endpackage

// ---- verilog/sacc_pin_share.sv ----
// Per-pin sharing logic: masks port reads and releases pull-downs of the selected input.
`timescale 1ns/1ps
`default_nettype none
module sacc_pin_share #(
   parameter int N = 8
) (
   // Selection
   input  wire logic [2:0]   sel,
   // Port side
   input  wire logic [N-1:0] port_raw,
   output logic      [N-1:0] port_masked,
   output logic      [N-1:0] pulldown_en
);
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_pin
         logic hit;
         assign hit = (sel == 3'(i));
         assign port_masked[i] = port_raw[i] & ~hit; // [R12]
         if (i >= sacc_pkg::DOWN_PIN_FIRST && i <= sacc_pkg::DOWN_PIN_LAST) begin : g_pd
            assign pulldown_en[i] = ~hit; // [R13]
         end else begin : g_nopd
            assign pulldown_en[i] = 1'b0;
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ---- verilog/sacc_ctrl.sv ----
// Top: compare code register, input select and comparator result capture.
`timescale 1ns/1ps
`default_nettype none
// Contract
// (R01) Four-bit compare code at peripheral 02H.
// (R02) Code selects ladder reference, zero is ground.
// (R03) Transfers use buffer high 0EH, low 0FH.
// (R04) Read returns code low, high nibble zero.
// (R05) Write loads low nibble, ignores high.
// (R06) Code undefined at power-on, held otherwise.
// (R07) Result is read-only bit 0 at 21H.
// (R08) Result one when input at or above.
// (R09) Result captured when register word peeked.
// (R10) Peek returns select in upper three bits.
// (R11) Select field routes one of eight inputs.
// (R12) Selected shared pin reads zero on port.
// (R13) Selected pull-down pins release their pull-down.
// (R14) Software sets group c one as inputs.
// (R15) Software runs successive approximation itself.
// (R16) Reference routine takes seventeen steps.
// (R17) Analogue part replaced by comparator input.
module sacc_ctrl #(
   parameter int NUM_IN = sacc_pkg::NUM_INPUTS
) (
   // Clock and reset
   input  wire logic                     CLK_SYS,
   input  wire logic                     RESET,
   // Peripheral transfer port
   input  wire sacc_pkg::sacc_periph_req_t PERIPH_REQ,
   output logic [7:0]                    GET_DATA,
   output logic                          GET_VALID,
   // Register file port
   input  wire sacc_pkg::sacc_rf_req_t   RF_REQ,
   output logic [3:0]                    PEEK_DATA,
   output logic                          PEEK_VALID,
   // Analogue stand-in
   input  wire logic                     CMP_ABOVE,
   output logic [3:0]                    COMPARE_CODE,
   output logic [2:0]                    INPUT_SELECT,
   // Shared port pins
   input  wire logic [NUM_IN-1:0]        PORT_RAW,
   output logic [NUM_IN-1:0]             PORT_READ,
   output logic [NUM_IN-1:0]             PULLDOWN_EN
);
   sacc_pkg::sacc_state_t s_q;
   sacc_pkg::sacc_state_t s_d;
   logic [NUM_IN-1:0] masked;
   logic [NUM_IN-1:0] pd;
   logic [NUM_IN-1:0] port_q;
   logic [NUM_IN-1:0] pd_q;
   logic              code_hit_put;
   logic              code_hit_get;
   logic              sel_hit_poke;
   logic              sel_hit_peek;

   // Decoded requests, shared by the checks at the bottom of the module.
   assign code_hit_put = PERIPH_REQ.put_stb
                         && (PERIPH_REQ.periph_addr == sacc_pkg::PERIPH_ADDR_CODE);
   assign code_hit_get = PERIPH_REQ.get_stb
                         && (PERIPH_REQ.periph_addr == sacc_pkg::PERIPH_ADDR_CODE);
   assign sel_hit_poke = RF_REQ.poke_stb
                         && (RF_REQ.rf_addr == sacc_pkg::REGFILE_ADDR_SEL);
   assign sel_hit_peek = RF_REQ.peek_stb
                         && (RF_REQ.rf_addr == sacc_pkg::REGFILE_ADDR_SEL);

   // Sharing uses the next select so the registered pins track the field with no lag.
   sacc_pin_share #(.N(NUM_IN)) u_share (
      .sel         (s_d.sel),
      .port_raw    (PORT_RAW),
      .port_masked (masked),
      .pulldown_en (pd)
   );

   always_comb begin
      s_d = s_q;
      s_d.get_valid = 1'b0;
      s_d.peek_valid = 1'b0;
      s_d.pin_mask = '0;
      if (PERIPH_REQ.put_stb && PERIPH_REQ.periph_addr == sacc_pkg::PERIPH_ADDR_CODE) begin
         s_d.code = PERIPH_REQ.put_data[3:0]; // [R01] [R03] [R05]
      end
      if (PERIPH_REQ.get_stb && PERIPH_REQ.periph_addr == sacc_pkg::PERIPH_ADDR_CODE) begin
         s_d.get_data = {sacc_pkg::HIGH_NIBBLE_READ, s_q.code}; // [R03] [R04]
         s_d.get_valid = 1'b1;
      end
      if (RF_REQ.poke_stb && RF_REQ.rf_addr == sacc_pkg::REGFILE_ADDR_SEL) begin
         // The result bit has no write path; only the select field takes poke data.
         s_d.sel = RF_REQ.poke_data[3:1]; // [R07] [R11]
      end
      if (RF_REQ.peek_stb && RF_REQ.rf_addr == sacc_pkg::REGFILE_ADDR_SEL) begin
         s_d.result = CMP_ABOVE; // [R08] [R09] [R17]
         s_d.peek_data = {s_q.sel, CMP_ABOVE}; // [R10]
         s_d.peek_valid = 1'b1;
      end
   end

   // The code is not cleared by reset: it must survive a chip-enable reset, and its
   // power-on value is free. The select is cleared so the pin masks are known from the first clock edge in reset.
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         s_q.sel        <= sacc_pkg::SEL_RESET_VALUE;
         s_q.get_valid  <= 1'b0;
         s_q.peek_valid <= 1'b0;
      end else begin
         s_q <= s_d; // [R06]
      end
   end

   always_ff @(posedge CLK_SYS) begin
      port_q <= masked;
      pd_q   <= pd;
   end

   assign GET_DATA     = s_q.get_data;
   assign GET_VALID    = s_q.get_valid;
   assign PEEK_DATA    = s_q.peek_data;
   assign PEEK_VALID   = s_q.peek_valid;
   assign COMPARE_CODE = s_q.code; // [R02]
   assign INPUT_SELECT = s_q.sel;
   assign PORT_READ    = port_q;
   assign PULLDOWN_EN  = pd_q;

   AST_GET_HIGH_ZERO: assert property (@(posedge CLK_SYS) disable iff (RESET) // [R04]
      GET_VALID |-> GET_DATA[7:4] == 4'h0)
      else $error("high nibble not zero on read");
   AST_PUT_LOADS: assert property (@(posedge CLK_SYS) disable iff (RESET) // [R05]
      (PERIPH_REQ.put_stb && PERIPH_REQ.periph_addr == 8'h02)
      |=> COMPARE_CODE == $past(PERIPH_REQ.put_data[3:0]))
      else $error("compare code not loaded");
   AST_GET_RETURNS: assert property (@(posedge CLK_SYS) disable iff (RESET) // [R01]
      (PERIPH_REQ.get_stb && !PERIPH_REQ.put_stb && PERIPH_REQ.periph_addr == 8'h02)
      |=> GET_VALID && GET_DATA[3:0] == COMPARE_CODE)
      else $error("read code mismatch");
   AST_HOLD_CODE: assert property (@(posedge CLK_SYS) disable iff (RESET) // [R06]
      !(PERIPH_REQ.put_stb && PERIPH_REQ.periph_addr == 8'h02) |=> $stable(COMPARE_CODE))
      else $error("code changed without write");
   AST_RESULT_CAPTURE: assert property (@(posedge CLK_SYS) disable iff (RESET) // [R09]
      (RF_REQ.peek_stb && RF_REQ.rf_addr == 8'h21)
      |=> PEEK_VALID && PEEK_DATA[0] == $past(CMP_ABOVE))
      else $error("result not captured at peek");
   AST_PEEK_SELECT: assert property (@(posedge CLK_SYS) disable iff (RESET) // [R10]
      (RF_REQ.peek_stb && !RF_REQ.poke_stb && RF_REQ.rf_addr == 8'h21)
      |=> PEEK_DATA[3:1] == INPUT_SELECT)
      else $error("peek select mismatch");
   AST_POKE_SELECT: assert property (@(posedge CLK_SYS) disable iff (RESET) // [R11]
      (RF_REQ.poke_stb && RF_REQ.rf_addr == 8'h21)
      |=> INPUT_SELECT == $past(RF_REQ.poke_data[3:1]))
      else $error("select not loaded");
   AST_PORT_MASK: assert property (@(posedge CLK_SYS) disable iff (RESET) // [R12]
      PORT_READ[INPUT_SELECT] == 1'b0)
      else $error("selected pin not masked");
   AST_PULLDOWN: assert property (@(posedge CLK_SYS) disable iff (RESET) // [R13]
      !PULLDOWN_EN[INPUT_SELECT] && PULLDOWN_EN[0] == 1'b0)
      else $error("pull-down not released");

   // Handshake pulses stand for exactly one cycle.
   AST_GET_PULSE: assert property (@(posedge CLK_SYS) disable iff (RESET) // [R04]
      !code_hit_get |=> !GET_VALID)
      else $error("read valid without read");

   AST_PEEK_PULSE: assert property (@(posedge CLK_SYS) disable iff (RESET) // [R09]
      !sel_hit_peek |=> !PEEK_VALID)
      else $error("peek valid without peek");

   AST_GET_OTHER: assert property (@(posedge CLK_SYS) disable iff (RESET) // [R01]
      (PERIPH_REQ.get_stb && !code_hit_get) |=> !GET_VALID)
      else $error("read answered at foreign address");

   // A read in the same cycle as a write returns the value from before the write.
   AST_GET_OLD_CODE: assert property (@(posedge CLK_SYS) disable iff (RESET) // [R04]
      code_hit_get |=> GET_DATA[3:0] == $past(COMPARE_CODE))
      else $error("read did not return prior code");

   AST_PEEK_OLD_SEL: assert property (@(posedge CLK_SYS) disable iff (RESET) // [R10]
      sel_hit_peek |=> PEEK_DATA[3:1] == $past(INPUT_SELECT))
      else $error("peek did not return prior select");

   AST_PUT_OTHER: assert property (@(posedge CLK_SYS) disable iff (RESET) // [R01]
      (PERIPH_REQ.put_stb && !code_hit_put) |=> $stable(COMPARE_CODE))
      else $error("foreign write changed the code");

   AST_SEL_HOLD: assert property (@(posedge CLK_SYS) disable iff (RESET) // [R11]
      !sel_hit_poke |=> $stable(INPUT_SELECT))
      else $error("select changed without poke");

   // A poke in the same cycle as a peek must not reach the result bit.
   AST_RESULT_NO_POKE: assert property (@(posedge CLK_SYS) disable iff (RESET) // [R07]
      (sel_hit_poke && sel_hit_peek) |=> PEEK_DATA[0] == $past(CMP_ABOVE))
      else $error("result bit took poke data");

   AST_RESULT_LEVEL: assert property (@(posedge CLK_SYS) disable iff (RESET) // [R08]
      (sel_hit_peek && CMP_ABOVE) |=> PEEK_DATA[0])
      else $error("result low with input above");

   // Unselected pins pass their raw level through with one cycle of delay.
   AST_PORT_PASS_LOW: assert property (@(posedge CLK_SYS) disable iff (RESET) // [R12]
      INPUT_SELECT != 3'h0 |-> PORT_READ[0] == $past(PORT_RAW[0]))
      else $error("unselected low pin altered");

   AST_PORT_PASS_HIGH: assert property (@(posedge CLK_SYS) disable iff (RESET) // [R12]
      INPUT_SELECT != 3'(NUM_IN - 1) |-> PORT_READ[NUM_IN-1] == $past(PORT_RAW[NUM_IN-1]))
      else $error("unselected high pin altered");

   AST_PD_FIRST_HELD: assert property (@(posedge CLK_SYS) disable iff (RESET) // [R13]
      INPUT_SELECT != 3'(sacc_pkg::DOWN_PIN_FIRST) |-> PULLDOWN_EN[sacc_pkg::DOWN_PIN_FIRST])
      else $error("first pull-down dropped while unselected");

   AST_PD_LAST_HELD: assert property (@(posedge CLK_SYS) disable iff (RESET) // [R13]
      INPUT_SELECT != 3'(sacc_pkg::DOWN_PIN_LAST) |-> PULLDOWN_EN[sacc_pkg::DOWN_PIN_LAST])
      else $error("last pull-down dropped while unselected");

   AST_PD_NONE_ABOVE: assert property (@(posedge CLK_SYS) disable iff (RESET) // [R13]
      PULLDOWN_EN[NUM_IN-1:sacc_pkg::DOWN_PIN_LAST+1] == '0)
      else $error("pull-down on pin without resistor");

endmodule
`default_nettype wire

// ---- tb/sacc_ctrl_analog.sv ----
// Stand-in for the ladder, input multiplexer and comparator on eight pins.
`timescale 1ns/1ps
`default_nettype none
module sacc_ctrl_analog (
   // Converter controls
   input  wire logic [3:0]  code,
   input  wire logic [2:0]  sel,
   // Pin levels in sixty-fourths of the supply, six bits per pin
   input  wire logic [47:0] volts,
   // Comparator
   output logic             cmp_above
);
   int ref_lvl;
   // Code n above zero sits at 4n-2 sixty-fourths and code 0 at ground, so every reference is an exact integer.
   always_comb begin
      ref_lvl = (code == 4'h0) ? 0 : 4 * code - 2;
      cmp_above = int'(volts[sel * 6 +: 6]) >= ref_lvl;
   end
endmodule
`default_nettype wire

// ---- tb/sacc_ctrl_bench.sv ----
// Self-checking bench for the converter control block against an integer model.
`timescale 1ns/1ps
`default_nettype none
module sacc_ctrl_bench;
   logic                       CLK_SYS, RESET, cmp, gval, pval;
   sacc_pkg::sacc_periph_req_t preq;
   sacc_pkg::sacc_rf_req_t     rreq;
   logic [7:0]                 gdat, praw, pread, pden;
   logic [3:0]                 pdat, code, code_m, trial;
   logic [2:0]                 sel, sel_m;
   logic [47:0]                volts;
   int                         n_mismatch, comparisons, v, ideal;
   sacc_ctrl i_sacc_ctrl (.CLK_SYS(CLK_SYS), .RESET(RESET), .PERIPH_REQ(preq),
      .GET_DATA(gdat), .GET_VALID(gval), .RF_REQ(rreq), .PEEK_DATA(pdat), .PEEK_VALID(pval),
      .CMP_ABOVE(cmp), .COMPARE_CODE(code), .INPUT_SELECT(sel), .PORT_RAW(praw),
      .PORT_READ(pread), .PULLDOWN_EN(pden));
   sacc_ctrl_analog i_sacc_ctrl_analog (.code(code), .sel(sel), .volts(volts), .cmp_above(cmp));
   initial begin
      CLK_SYS = 1'b0;
      forever #2.5 CLK_SYS = ~CLK_SYS;
   end
   task automatic summarize;
      $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // The high nibble is random because the register must ignore it.
   task automatic put(input logic [7:0] a, input logic [3:0] c);
      preq = '{1'b1, 1'b0, a, {4'($urandom), c}};
      @(negedge CLK_SYS);
      preq.put_stb = 1'b0;
      if (a == 8'h02) code_m = c;
      @(negedge CLK_SYS);
   endtask
   task automatic get;
      preq = '{1'b0, 1'b1, 8'h02, 8'h00};
      @(negedge CLK_SYS);
      preq.get_stb = 1'b0;
      chk({7'h0, gval}, 8'h01);
      chk(gdat, {4'h0, code_m});
      chk({4'h0, code}, {4'h0, code_m});
      @(negedge CLK_SYS);
      chk({7'h0, gval}, 8'h00);
   endtask
   task automatic poke(input logic [2:0] s);
      rreq = '{1'b0, 1'b1, 8'h21, {s, 1'($urandom)}};
      @(negedge CLK_SYS);
      rreq.poke_stb = 1'b0;
      sel_m = s;
      @(negedge CLK_SYS);
   endtask
   task automatic peek;
      v = volts[sel_m * 6 +: 6];
      rreq = '{1'b1, 1'b0, 8'h21, 4'h0};
      @(negedge CLK_SYS);
      rreq.peek_stb = 1'b0;
      chk({7'h0, pval}, 8'h01);
      chk({4'h0, pdat}, {4'h0, sel_m, v >= ((code_m == 4'h0) ? 0 : 4 * code_m - 2)});
      @(negedge CLK_SYS);
      chk({7'h0, pval}, 8'h00);
   endtask
   initial begin
      #200000;
      n_mismatch++;
      summarize();
   end
   initial begin
      n_mismatch = 0;
      comparisons = 0;
      RESET = 1'b1;
      preq = '0;
      rreq = '0;
      praw = '0;
      void'($urandom(32'hfbdaacf1));
      for (int i = 0; i < 8; i++) volts[i * 6 +: 6] = 6'($urandom);
      // Pin 0 sits exactly on a reference, pins 1 and 7 at the rails.
      volts[17:0] = {6'd20, 6'd0, 6'd30};
      volts[47:42] = 6'd63;
      repeat (16) @(negedge CLK_SYS);
      RESET = 1'b0;
      put(8'h02, 4'ha);
      get();
      put(8'h03, 4'h5);
      get();
      for (int s = 0; s < 8; s++) begin
         praw = 8'($urandom);
         poke(3'(s));
         peek();
         chk(pread, praw & ~(8'h01 << s));
         chk(pden, 8'h1e & ~(8'h01 << s));
         trial = 4'h0;
         // Four trials, most significant first, as the reference routine does.
         for (int b = 3; b >= 0; b--) begin
            trial[b] = 1'b1;
            put(8'h02, trial);
            peek();
            if (pdat[0] !== 1'b1) trial[b] = 1'b0;
         end
         ideal = 0;
         for (int n = 1; n < 16; n++) if (volts[s * 6 +: 6] >= 4 * n - 2) ideal = n;
         chk({4'h0, trial}, 8'(ideal));
      end
      RESET = 1'b1;
      repeat (3) @(negedge CLK_SYS);
      RESET = 1'b0;
      sel_m = sacc_pkg::SEL_RESET_VALUE;
      get();
      peek();
      summarize();
   end
endmodule
`default_nettype wire
